// file: include/hppp_map.svh
// Offsets, field positions, reset values and timing counts of the host parallel port.
`ifndef HPPP_MAP_SVH
`define HPPP_MAP_SVH

// Software register offsets (byte addresses, one 32-bit word each).
`define HPPP_OFF_SYSCFG 12'h000
`define HPPP_OFF_STATUS 12'h004
`define HPPP_OFF_MASK 12'h008
`define HPPP_OFF_HIRQ 12'h00c
`define HPPP_OFF_ADDRREG 12'h010
// Address bit that selects the shared word memory window (0x800 to 0xfff).
`define HPPP_MEM_SEL_BIT 11

// System configuration register fields and reset value.
`define HPPP_SYS_HOLD_BIT 0
`define HPPP_SYS_PULL_BIT 1
`define HPPP_SYS_RESET 2'h1

// Host control register fields.
`define HPPP_HCTL_IRQ_BIT 0
`define HPPP_HCTL_MODE_BIT 1

// Event bits of the status and mask registers.
`define HPPP_EV_WRITE 0
`define HPPP_EV_READ 1
`define HPPP_EV_ASTROBE 2
`define HPPP_EV_BYTEEN 3
`define HPPP_EV_NUM 4

// Access time per host transfer, and the clock period, in ns.
`define HPPP_ACCESS_NS 200
`define HPPP_CLK_NS 100
`define HPPP_ACCESS_CYC ((`HPPP_ACCESS_NS + `HPPP_CLK_NS - 1) / `HPPP_CLK_NS)

`endif

// file: include/hppp_pkg.sv
// Types shared by the host parallel port design.
package hppp_pkg;

  // Host-side input pins, taken as synchronous to clk_i.
  typedef struct packed {
    logic [19:0] host_addr_bus;
    logic mux_mode_select;
    logic port_chip_select_n;
    logic host_rw_select;
    logic host_data_strobe_a_n;
    logic host_data_strobe_b_n;
    logic host_ctrl_sel0;
    logic host_byte_en_lo;
    logic host_byte_en_hi;
  } hppp_host_in_t;

  // Target of one host access.
  typedef enum logic [1:0] {
    HPPP_SEL_CTRL = 2'h0,
    HPPP_SEL_DATA_INC = 2'h1,
    HPPP_SEL_ADDR = 2'h2,
    HPPP_SEL_DATA = 2'h3
  } hppp_sel_t;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    HPPP_ST_IDLE = 3'h1,
    HPPP_ST_BUSY = 3'h2,
    HPPP_ST_HOLD = 3'h4
  } hppp_state_t;

endpackage

// file: src/hppp_dpram.sv
// Word memory shared between the host port and local software.
module hppp_dpram #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic a_we_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [DW-1:0] a_wdata_i,
  output logic [DW-1:0] a_rdata_o,
  input wire logic b_we_i,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [DW-1:0] b_wdata_i,
  output logic [DW-1:0] b_rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // Software port writes last, so it wins a same-word collision.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (a_we_i) begin
        mem[a_addr_i] <= a_wdata_i;
      end
      if (b_we_i) begin
        mem[b_addr_i] <= b_wdata_i;
      end
    end
  end

  // Reads are combinational; the caller registers them.
  assign a_rdata_o = mem[a_addr_i];
  assign b_rdata_o = mem[b_addr_i];

endmodule

// file: src/hppp_top.sv
// Device end of the sixteen-bit host parallel port with its software registers.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "hppp_map.svh"

module hppp_top #(
  parameter int AW = 9,
  parameter int ACCESS_CYC = `HPPP_ACCESS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire hppp_pkg::hppp_host_in_t host_i,
  input wire logic [15:0] host_data_bus_i,
  output logic [15:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic port_ready_out_o,
  output logic host_irq_out_n_o,
  output logic bus_holder_en_o,
  output logic pullup_en_o,
  input wire logic [11:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  output logic irq_o
);

  localparam logic [3:0] WAIT_LAST = 4'(ACCESS_CYC - 1);

  hppp_pkg::hppp_state_t state;
  hppp_pkg::hppp_sel_t sel_now;
  logic acc_rw;
  logic [3:0] wait_cnt;
  logic act;
  logic act_q;
  logic start;
  logic astb_q;
  logic astb_fall;
  logic [19:0] addr_reg;
  logic [AW-1:0] host_idx;
  logic [15:0] host_mem_rdata;
  logic host_mem_we;
  logic [15:0] sw_mem_rdata;
  logic sw_mem_we;
  logic [1:0] syscfg;
  logic [`HPPP_EV_NUM-1:0] status;
  logic [`HPPP_EV_NUM-1:0] mask;
  logic [`HPPP_EV_NUM-1:0] ev;
  logic [15:0] ctrl_word;
  logic sw_sel_mem;

  // Either strobe polarity works: the pair differing means a strobe is active.
  // strobe qualifies transfer
  assign act = ~host_i.port_chip_select_n
             & (host_i.host_data_strobe_a_n ^ host_i.host_data_strobe_b_n);
  assign start = act & ~act_q & (state == hppp_pkg::HPPP_ST_IDLE);

  assign astb_fall = ~host_i.mux_mode_select & ~host_i.port_chip_select_n
                   & astb_q & ~host_i.host_addr_bus[2];

  // Access target from the mode and the control selects.
  always_comb begin
    if (host_i.mux_mode_select) begin
      sel_now = host_i.host_ctrl_sel0 ? hppp_pkg::HPPP_SEL_CTRL : hppp_pkg::HPPP_SEL_DATA;
    end else begin
      sel_now = hppp_pkg::hppp_sel_t'({host_i.host_addr_bus[1], host_i.host_ctrl_sel0});
    end
  end

  // Word index used for host data accesses.
  always_comb begin
    if (host_i.mux_mode_select) begin
      host_idx = host_i.host_addr_bus[AW-1:0];
    end else begin
      host_idx = addr_reg[AW-1:0];
    end
  end

  // Byte enables never gate a write: every data write covers all sixteen bits.
  // full-word writes only
  assign host_mem_we = start & ~host_i.host_rw_select
                     & ((sel_now == hppp_pkg::HPPP_SEL_DATA)
                     | (sel_now == hppp_pkg::HPPP_SEL_DATA_INC));

  // Control word as the host sees it.
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`HPPP_HCTL_IRQ_BIT] = ~host_irq_out_n_o;
    ctrl_word[`HPPP_HCTL_MODE_BIT] = host_i.mux_mode_select;
  end

  assign sw_sel_mem = sw_addr_i[`HPPP_MEM_SEL_BIT];
  assign sw_mem_we = sw_wr_i & sw_sel_mem;

  hppp_dpram #(
    .AW(AW),
    .DW(16)
  ) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .a_we_i(host_mem_we),
    .a_addr_i(host_idx),
    .a_wdata_i(host_data_bus_i),
    .a_rdata_o(host_mem_rdata),
    .b_we_i(sw_mem_we),
    .b_addr_i(sw_addr_i[AW+1:2]),
    .b_wdata_i(sw_wdata_i[15:0]),
    .b_rdata_o(sw_mem_rdata)
  );

  // Edge history of the strobe and address strobe.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_q <= 1'b0;
      astb_q <= 1'b1;
    end else if (ce_i) begin
      act_q <= act;
      astb_q <= host_i.host_addr_bus[2];
    end
  end

  // Transfer sequencer: busy for the access time, then hold until the strobe ends.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= hppp_pkg::HPPP_ST_IDLE;
      wait_cnt <= 4'h0;
      acc_rw <= 1'b0;
    end else if (ce_i) begin
      case (state)
        hppp_pkg::HPPP_ST_IDLE: begin
          if (start) begin
            state <= hppp_pkg::HPPP_ST_BUSY;
            wait_cnt <= 4'h0;
            acc_rw <= host_i.host_rw_select;
          end
        end
        hppp_pkg::HPPP_ST_BUSY: begin
          if (wait_cnt == WAIT_LAST) begin
            state <= hppp_pkg::HPPP_ST_HOLD;
          end else begin
            wait_cnt <= wait_cnt + 4'h1;
          end
        end
        hppp_pkg::HPPP_ST_HOLD: begin
          if (!act) begin
            state <= hppp_pkg::HPPP_ST_IDLE;
          end
        end
        default: begin
          state <= hppp_pkg::HPPP_ST_IDLE;
        end
      endcase
    end
  end

  // Ready drops as a transfer is taken and returns once the access time is over.
  // ready handshake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_ready_out_o <= 1'b1;
    end else if (ce_i) begin
      if (start) begin
        port_ready_out_o <= 1'b0;
      end else if (state == hppp_pkg::HPPP_ST_BUSY && wait_cnt == WAIT_LAST) begin
        port_ready_out_o <= 1'b1;
      end
    end
  end

  // Address register: direct write, address strobe latch, and auto-increment.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= 20'h00000;
    end else if (ce_i) begin
      if (astb_fall) begin
        addr_reg[15:0] <= host_data_bus_i;
      end else if (start && !host_i.mux_mode_select) begin
        if (sel_now == hppp_pkg::HPPP_SEL_ADDR && !host_i.host_rw_select) begin
          addr_reg[15:0] <= host_data_bus_i;
        end else if (sel_now == hppp_pkg::HPPP_SEL_DATA_INC) begin
          addr_reg <= addr_reg + 20'h00001;
        end
      end
    end
  end

  // Read data is captured as the strobe is taken and held for the transfer.
  // read direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_bus_o <= 16'h0000;
    end else if (ce_i) begin
      if (start && host_i.host_rw_select) begin
        case (sel_now)
          hppp_pkg::HPPP_SEL_CTRL: host_data_bus_o <= ctrl_word;
          hppp_pkg::HPPP_SEL_ADDR: host_data_bus_o <= addr_reg[15:0];
          default: host_data_bus_o <= host_mem_rdata;
        endcase
      end
    end
  end

  // The bus is driven only while a read strobe is still active.
  // two-way data bus
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_bus_oe_o <= 1'b0;
    end else if (ce_i) begin
      host_data_bus_oe_o <= act & ((start & host_i.host_rw_select)
                          | ((state != hppp_pkg::HPPP_ST_IDLE) & acc_rw));
    end
  end

  // Host interrupt, active low. Software raises it; the host acknowledges by
  // writing a one to the control word. A raise in the same cycle wins.
  // host interrupt output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_irq_out_n_o <= 1'b1;
    end else if (ce_i) begin
      if (sw_wr_i && !sw_sel_mem && sw_addr_i == `HPPP_OFF_HIRQ
          && sw_wdata_i[`HPPP_HCTL_IRQ_BIT]) begin
        host_irq_out_n_o <= 1'b0;
      end else if (start && !host_i.host_rw_select && sel_now == hppp_pkg::HPPP_SEL_CTRL
                   && host_data_bus_i[`HPPP_HCTL_IRQ_BIT]) begin
        host_irq_out_n_o <= 1'b1;
      end
    end
  end

  // System configuration: holder and pullup enables for the pads.
  // holder enable bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syscfg <= `HPPP_SYS_RESET;
      bus_holder_en_o <= 1'(`HPPP_SYS_RESET >> `HPPP_SYS_HOLD_BIT);
      pullup_en_o <= 1'b0;
    end else if (ce_i) begin
      if (sw_wr_i && !sw_sel_mem && sw_addr_i == `HPPP_OFF_SYSCFG) begin
        syscfg <= sw_wdata_i[1:0];
      end
      bus_holder_en_o <= syscfg[`HPPP_SYS_HOLD_BIT];
      pullup_en_o <= syscfg[`HPPP_SYS_PULL_BIT];
    end
  end

  // Port events that software can watch.
  always_comb begin
    ev = '0;
    ev[`HPPP_EV_WRITE] = start & ~host_i.host_rw_select;
    ev[`HPPP_EV_READ] = start & host_i.host_rw_select;
    ev[`HPPP_EV_ASTROBE] = astb_fall;
    // Byte enables left high are a host fault; they are flagged, not honoured.
    ev[`HPPP_EV_BYTEEN] = start & (host_i.host_byte_en_lo | host_i.host_byte_en_hi);
  end

  // Sticky status bits, cleared by writing one; a new event beats the clear.
  for (genvar i = 0; i < `HPPP_EV_NUM; i++) begin : g_status
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        status[i] <= 1'b0;
      end else if (ce_i) begin
        if (ev[i]) begin
          status[i] <= 1'b1;
        end else if (sw_wr_i && !sw_sel_mem && sw_addr_i == `HPPP_OFF_STATUS
                     && sw_wdata_i[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask and the level interrupt line.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (sw_wr_i && !sw_sel_mem && sw_addr_i == `HPPP_OFF_MASK) begin
        mask <= sw_wdata_i[`HPPP_EV_NUM-1:0];
      end
      irq_o <= |(status & mask);
    end
  end

  // Software read data, valid the cycle after the read strobe only.
  // Unmapped offsets read as zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      sw_rdata_o <= 32'h00000000;
      if (sw_rd_i) begin
        if (sw_sel_mem) begin
          sw_rdata_o <= {16'h0000, sw_mem_rdata};
        end else begin
          case (sw_addr_i)
            `HPPP_OFF_SYSCFG: sw_rdata_o <= {30'h0, syscfg};
            `HPPP_OFF_STATUS: sw_rdata_o <= {28'h0000000, status};
            `HPPP_OFF_MASK: sw_rdata_o <= {28'h0000000, mask};
            `HPPP_OFF_HIRQ: sw_rdata_o <= {16'h0000, ctrl_word};
            `HPPP_OFF_ADDRREG: sw_rdata_o <= {12'h000, addr_reg};
            default: sw_rdata_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule

// file: sim/hppp_monitor.sv
// Checker of the host parallel port, watching the top module's ports only.
`include "hppp_map.svh"
module hppp_monitor #(
  parameter int ACCESS_CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire hppp_pkg::hppp_host_in_t host_i,
  input wire logic [15:0] host_data_bus_i,
  input wire logic [15:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  input wire logic port_ready_out_o,
  input wire logic host_irq_out_n_o,
  input wire logic bus_holder_en_o,
  input wire logic pullup_en_o,
  input wire logic [11:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  input wire logic [31:0] sw_rdata_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A strobe is live while selected and the two strobe pins differ.
  wire logic act = !host_i.port_chip_select_n &&
    (host_i.host_data_strobe_a_n != host_i.host_data_strobe_b_n);
  wire logic rw = host_i.host_rw_select;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ready_on_take_a: assert property (
    !act ##1 !act ##1 (act && port_ready_out_o) |=> !port_ready_out_o)
    else $error("ready stayed high after a new strobe");
  ready_return_a: assert property (
    $fell(port_ready_out_o) |-> ##ACCESS_CYC port_ready_out_o)
    else $error("ready did not return after the access time");
  idle_ready_a: assert property (!act [*3] |-> port_ready_out_o)
    else $error("ready low while the port is idle");
  read_drive_a: assert property (
    !act ##1 !act ##1 (act && port_ready_out_o && rw) |=> host_data_bus_oe_o)
    else $error("read did not drive the data bus");
  write_quiet_a: assert property (
    !act ##1 !act ##1 (act && port_ready_out_o && !rw) |=> !host_data_bus_oe_o)
    else $error("write drove the data bus");
  bus_release_a: assert property ($fell(act) |-> ##2 !host_data_bus_oe_o)
    else $error("data bus still driven after the strobe ended");
  irq_raise_a: assert property (
    ce_i && sw_wr_i && sw_addr_i == `HPPP_OFF_HIRQ && sw_wdata_i[0] |=> !host_irq_out_n_o)
    else $error("host interrupt not raised by software");
  irq_ack_a: assert property (
    !act ##1 !act ##1 (act && port_ready_out_o && !rw && !host_i.mux_mode_select &&
    !host_i.host_addr_bus[1] && !host_i.host_ctrl_sel0 && host_data_bus_i[0] && !sw_wr_i)
    |=> host_irq_out_n_o)
    else $error("control write did not clear the host interrupt");
  holder_follow_a: assert property (
    ce_i && sw_wr_i && sw_addr_i == `HPPP_OFF_SYSCFG ##1 !sw_wr_i
    |=> bus_holder_en_o == $past(sw_wdata_i[0], 2))
    else $error("holder enable does not follow the config bit");
endmodule

// file: sim/hppp_host_model.sv
// Behavioural external host that runs bus cycles on the parallel port.
module hppp_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [15:0] data_i,
  output hppp_pkg::hppp_host_in_t host_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // byte enables low; idle chip select high.
  hppp_pkg::hppp_host_in_t h = '{host_addr_bus: 20'h00004, port_chip_select_n: 1'b1,
    host_data_strobe_a_n: 1'b1, host_data_strobe_b_n: 1'b1, default: 1'b0};
  logic [15:0] hd = 16'h0;
  assign host_o = h;
  assign data_o = hd;

  // One full word transfer; d carries write data in and read data out.
  task automatic xfer(input logic mode, input logic rd, input logic sel0,
                      input logic [19:0] a, inout logic [15:0] d);
    int n;
    n = 0;
    // selects held for the whole access.
    h.mux_mode_select <= mode;
    h.host_ctrl_sel0 <= sel0;
    h.host_addr_bus <= a;
    h.host_rw_select <= rd;
    h.port_chip_select_n <= 1'b0;
    hd <= d;
    h.host_data_strobe_a_n <= 1'b0;
    do @(posedge clk_i); while (ready_i !== 1'b0 && ++n < 9);
    while (ready_i !== 1'b1 && ++n < 9) @(posedge clk_i);
    if (rd) d = data_i;
    h.host_data_strobe_a_n <= 1'b1;
    @(posedge clk_i);
    h.port_chip_select_n <= 1'b1;
    hd <= ~d; // A released bus must not keep showing the old word.
    @(posedge clk_i);
  endtask

  // address strobe latches the bus word.
  task automatic astrobe(input logic [15:0] v);
    h.mux_mode_select <= 1'b0;
    h.port_chip_select_n <= 1'b0;
    hd <= v;
    @(posedge clk_i);
    h.host_addr_bus[2] <= 1'b0;
    repeat (2) @(posedge clk_i);
    h.host_addr_bus[2] <= 1'b1;
    h.port_chip_select_n <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule

// file: sim/test_host_parallel_port_pins.sv
// Self-checking bench of the host parallel port top level.
`include "hppp_map.svh"
module test_host_parallel_port_pins;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [11:0] sw_addr_i = 12'h0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic [31:0] sw_rdata_o;
  hppp_pkg::hppp_host_in_t host_i;
  logic [15:0] host_data_bus_i, host_data_bus_o, host_d, d;
  logic host_data_bus_oe_o, port_ready_out_o, host_irq_out_n_o, bus_holder_en_o, irq_o;
  logic pullup_en_o;
  logic ce_i = 1'b1;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;

  hppp_top #(.ACCESS_CYC(2)) i_hppp_top (.clk_i, .rst_n_i, .ce_i, .host_i,
    .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o, .port_ready_out_o,
    .host_irq_out_n_o, .bus_holder_en_o, .pullup_en_o, .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o, .irq_o);
  hppp_host_model i_hppp_host_model (.clk_i, .ready_i(port_ready_out_o),
    .data_i(host_data_bus_i), .host_o(host_i), .data_o(host_d));
  // The shared wire carries the device word while it drives, else the host's.
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : host_d;

  // Free-running clock and a cycle ceiling well above the whole run.
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic sw_wr(input logic [11:0] a, input logic [31:0] v);
    sw_addr_i <= a;
    sw_wdata_i <= v;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Read data stands only in the cycle after the strobe, so it is judged there.
  task automatic sw_rd(input logic [11:0] a, input logic [31:0] exp);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    @(posedge clk_i);
    check(sw_rdata_o, exp);
  endtask

  task automatic t_reset();
    check(32'(host_irq_out_n_o), 32'h1);
    check(32'(port_ready_out_o), 32'h1);
    check(32'(host_data_bus_oe_o), 32'h0);
    check(32'(bus_holder_en_o), 32'h1);
  endtask

  // Multiplexed mode with junk on the upper address lines.
  task automatic t_mux();
    i_hppp_host_model.astrobe(16'h0005);
    sw_rd(`HPPP_OFF_ADDRREG, 32'h5);
    d = 16'h1234;
    i_hppp_host_model.xfer(1'b0, 1'b0, 1'b1, 20'hfffff, d);
    sw_rd(12'h814, 32'h1234);
    d = 16'h0;
    i_hppp_host_model.xfer(1'b0, 1'b1, 1'b1, 20'ha5a56, d);
    check({16'h0, d}, 32'h1234);
    sw_rd(`HPPP_OFF_STATUS, 32'h7);
    d = 16'h0009;
    i_hppp_host_model.xfer(1'b0, 1'b0, 1'b0, 20'h00006, d);
    sw_rd(`HPPP_OFF_ADDRREG, 32'h9);
    // Data access with increment: word 9 is written, then the pointer moves on.
    d = 16'h5a5a;
    i_hppp_host_model.xfer(1'b0, 1'b0, 1'b1, 20'h00004, d);
    sw_rd(12'h824, 32'h5a5a);
    sw_rd(`HPPP_OFF_ADDRREG, 32'ha);
  endtask

  // Dedicated address bus: line 2 low must not act as a strobe.
  task automatic t_nomux();
    d = 16'habcd;
    i_hppp_host_model.xfer(1'b1, 1'b0, 1'b0, 20'h00003, d);
    sw_rd(12'h80c, 32'habcd);
    sw_rd(`HPPP_OFF_ADDRREG, 32'ha);
  endtask

  task automatic t_irq();
    sw_wr(`HPPP_OFF_HIRQ, 32'h1);
    check(32'(host_irq_out_n_o), 32'h0);
    // Control read in multiplexed mode shows the pending host interrupt.
    d = 16'h0000;
    i_hppp_host_model.xfer(1'b0, 1'b1, 1'b0, 20'h00004, d);
    check({16'h0, d}, 32'h1);
    d = 16'h0001;
    i_hppp_host_model.xfer(1'b0, 1'b0, 1'b0, 20'h00004, d);
    check(32'(host_irq_out_n_o), 32'h1);
    sw_wr(`HPPP_OFF_STATUS, 32'hf);
    sw_wr(`HPPP_OFF_MASK, 32'h8);
    i_hppp_host_model.h.host_byte_en_hi <= 1'b1;
    i_hppp_host_model.xfer(1'b0, 1'b0, 1'b1, 20'h00006, d);
    i_hppp_host_model.h.host_byte_en_hi <= 1'b0;
    sw_rd(`HPPP_OFF_STATUS, 32'h9);
    check(32'(irq_o), 32'h1);
    sw_wr(`HPPP_OFF_MASK, 32'h0);
    @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    sw_rd(12'h020, 32'h0);
  endtask

  task automatic t_holder();
    sw_wr(`HPPP_OFF_SYSCFG, 32'h0);
    @(posedge clk_i);
    check(32'(bus_holder_en_o), 32'h0);
    sw_wr(`HPPP_OFF_SYSCFG, 32'h1);
    @(posedge clk_i);
    check(32'(bus_holder_en_o), 32'h1);
    sw_wr(`HPPP_OFF_SYSCFG, 32'h2);
    @(posedge clk_i);
    check(32'(pullup_en_o), 32'h1);
    check(32'(bus_holder_en_o), 32'h0);
    sw_rd(`HPPP_OFF_SYSCFG, 32'h2);
    // A reset in mid-run must bring the host interrupt back high.
    sw_wr(`HPPP_OFF_HIRQ, 32'h1);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    check(32'(host_irq_out_n_o), 32'h1);
    check(32'(bus_holder_en_o), 32'h1);
    check(32'(pullup_en_o), 32'h0);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // With the clock enable low a raise request must be frozen out.
    ce_i <= 1'b0;
    sw_wr(`HPPP_OFF_HIRQ, 32'h1);
    ce_i <= 1'b1;
    check(32'(host_irq_out_n_o), 32'h1);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    t_reset();
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_mux();
    t_nomux();
    t_irq();
    t_holder();
    print_verdict();
  end
endmodule

bind hppp_top hppp_monitor #(.ACCESS_CYC(ACCESS_CYC)) i_hppp_monitor (.clk_i, .rst_n_i,
  .ce_i, .host_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o,
  .port_ready_out_o, .host_irq_out_n_o, .bus_holder_en_o, .pullup_en_o, .sw_addr_i,
  .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o, .irq_o);
